/* File: common/adc_seq_pkg.sv */
package adc_seq_pkg;
  localparam int unsigned ADDR_W = 16;
  // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
  localparam logic [15:0] IDX_SC1 = 16'h0010;
  localparam logic [15:0] IDX_SC2 = 16'h0011;
  localparam logic [15:0] IDX_SC3 = 16'h0012;
  localparam logic [15:0] IDX_SC4 = 16'h0013;
  localparam logic [15:0] IDX_RH = 16'h0014;
  localparam logic [15:0] IDX_RL = 16'h0015;
  localparam logic [15:0] IDX_CVH = 16'h0016;
  localparam logic [15:0] IDX_CVL = 16'h0017;
  localparam logic [15:0] IDX_PC1 = 16'h30ac;
  localparam logic [15:0] IDX_PC2 = 16'h30ad;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h0018;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0019;

  localparam logic [7:0] SC1_RST = 8'h1f;
  localparam logic [7:0] SC2_RST = 8'h08;
  localparam logic [7:0] ZERO8 = 8'h00;

  localparam int unsigned SC1_COMPLETE_BIT = 7;
  localparam int unsigned SC1_IEN_BIT = 6;
  localparam int unsigned SC1_CONT_BIT = 5;
  localparam int unsigned SC2_ACTIVE_BIT = 7;
  localparam int unsigned SC2_TRIG_BIT = 6;
  localparam int unsigned SC2_CMP_EN_BIT = 5;
  localparam int unsigned SC2_CMP_GE_BIT = 4;
  localparam int unsigned SC2_FEMPTY_BIT = 3;

  localparam logic [4:0] CH_DISABLED = 5'h1f;
  localparam logic [4:0] CH_EXT_LAST = 5'h0f;
  localparam logic [4:0] CH_GND_FIRST = 5'h10;
  localparam logic [4:0] CH_GND_LAST = 5'h13;
  localparam logic [4:0] CH_TEMP = 5'h16;
  localparam logic [4:0] CH_BANDGAP = 5'h17;
  localparam logic [4:0] CH_VREFH = 5'h1d;
  localparam logic [4:0] CH_VREFL = 5'h1e;

  // Interrupt status bits
  localparam int unsigned IRQ_COMPLETE_BIT = 0;
  localparam int unsigned IRQ_ABORT_BIT = 1;

  typedef enum logic [2:0] {
    SRC_EXTERNAL,
    SRC_GROUND,
    SRC_TEMP,
    SRC_BANDGAP,
    SRC_VREFH,
    SRC_VREFL,
    SRC_RESERVED,
    SRC_OFF
  } src_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FILL,
    ST_CONVERT
  } seq_state_t;
endpackage

/* File: rtl/adc_conversion_sequencer.sv */
module adc_conversion_sequencer #(
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned RES_W = 12
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [adc_seq_pkg::ADDR_W+1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic hardware_trigger_input_i,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic [4:0] conv_channel_o,
  output logic [2:0] conv_source_o,
  input wire logic conv_done_i,
  input wire logic [RES_W-1:0] conv_result_i,
  output logic [7:0] pin_control_one_o,
  output logic [7:0] pin_control_two_o,
  output logic irq_o
);

  localparam int unsigned PTR_W = $clog2(FIFO_DEPTH);
  localparam logic [PTR_W:0] CNT_ONE = (PTR_W+1)'(1);

  typedef struct packed {
    adc_seq_pkg::seq_state_t state;
    logic [7:0] sc1;
    logic [7:0] sc2;
    logic [7:0] sc3;
    logic [7:0] sc4;
    logic [15:0] result;
    logic [15:0] cmp_val;
    logic [7:0] pc1;
    logic [7:0] pc2;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [FIFO_DEPTH-1:0][4:0] queue;
    logic [PTR_W:0] fill_cnt;
    logic [PTR_W:0] rd_idx;
    logic set_hit;
    logic trig_prev;
    logic start;
    logic abort;
    logic [4:0] chan;
    logic [31:0] rdata;
  } state_t;

  state_t cur_reg;
  state_t cur_next;

  logic apb_access;
  logic wr_en;
  logic rd_en;
  logic [adc_seq_pkg::ADDR_W-1:0] idx;
  logic mapped;
  logic [7:0] wbyte;
  logic [PTR_W:0] depth;
  logic fifo_mode;
  logic cont;
  logic hw_mode;
  logic trig_edge;
  logic cmp_true;
  logic [15:0] res_ext;
  logic last_in_set;
  logic start_req;

  function automatic logic [2:0] decode_src(input logic [4:0] ch);
    adc_seq_pkg::src_kind_t k;
    k = adc_seq_pkg::SRC_RESERVED;
    if (ch <= adc_seq_pkg::CH_EXT_LAST) begin
      k = adc_seq_pkg::SRC_EXTERNAL;
    end else if (ch >= adc_seq_pkg::CH_GND_FIRST && ch <= adc_seq_pkg::CH_GND_LAST) begin
      k = adc_seq_pkg::SRC_GROUND;
    end else if (ch == adc_seq_pkg::CH_TEMP) begin
      k = adc_seq_pkg::SRC_TEMP;
    end else if (ch == adc_seq_pkg::CH_BANDGAP) begin
      k = adc_seq_pkg::SRC_BANDGAP;
    end else if (ch == adc_seq_pkg::CH_VREFH) begin
      k = adc_seq_pkg::SRC_VREFH;
    end else if (ch == adc_seq_pkg::CH_VREFL) begin
      k = adc_seq_pkg::SRC_VREFL;
    end else if (ch == adc_seq_pkg::CH_DISABLED) begin
      k = adc_seq_pkg::SRC_OFF;
    end
    return 3'(k);
  endfunction

  assign apb_access = psel_i && penable_i;
  assign wr_en = apb_access && pwrite_i && pstrb_i[0];
  assign rd_en = apb_access && !pwrite_i;
  assign idx = paddr_i[adc_seq_pkg::ADDR_W+1:2];
  assign wbyte = pwdata_i[7:0];
  // Depth field is the low three bits, clipped to the queue size
  assign depth = ((PTR_W+1)'(cur_reg.sc4[2:0]) > (PTR_W+1)'(FIFO_DEPTH)) ?
                 (PTR_W+1)'(FIFO_DEPTH) : (PTR_W+1)'(cur_reg.sc4[2:0]);
  assign fifo_mode = (depth != '0);
  assign cont = cur_reg.sc1[adc_seq_pkg::SC1_CONT_BIT];
  assign hw_mode = cur_reg.sc2[adc_seq_pkg::SC2_TRIG_BIT];
  assign trig_edge = hardware_trigger_input_i && !cur_reg.trig_prev;
  assign res_ext = 16'(conv_result_i);
  assign cmp_true = cur_reg.sc2[adc_seq_pkg::SC2_CMP_GE_BIT] ?
                    (res_ext >= cur_reg.cmp_val) : (res_ext < cur_reg.cmp_val);
  assign last_in_set = !fifo_mode || (cur_reg.rd_idx + CNT_ONE >= depth);

  always_comb begin
    case (idx)
      adc_seq_pkg::IDX_SC1, adc_seq_pkg::IDX_SC2, adc_seq_pkg::IDX_SC3,
      adc_seq_pkg::IDX_SC4, adc_seq_pkg::IDX_RH, adc_seq_pkg::IDX_RL,
      adc_seq_pkg::IDX_CVH, adc_seq_pkg::IDX_CVL, adc_seq_pkg::IDX_PC1,
      adc_seq_pkg::IDX_PC2, adc_seq_pkg::IDX_IRQ_STAT,
      adc_seq_pkg::IDX_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    logic sc1_wr;
    logic halt;
    logic complete_evt;
    logic abort_evt;
    sc1_wr = 1'b0;
    halt = 1'b0;
    complete_evt = 1'b0;
    abort_evt = 1'b0;
    start_req = 1'b0;
    cur_next = cur_reg;
    cur_next.start = 1'b0;
    cur_next.abort = 1'b0;
    cur_next.trig_prev = hardware_trigger_input_i;

    // Register writes
    if (wr_en && mapped) begin
      case (idx)
        adc_seq_pkg::IDX_SC1: begin
          sc1_wr = 1'b1;
          cur_next.sc1 = {1'b0, wbyte[6:0]};
        end
        adc_seq_pkg::IDX_SC2: cur_next.sc2[6:4] = wbyte[6:4];
        adc_seq_pkg::IDX_SC3: cur_next.sc3 = wbyte;
        adc_seq_pkg::IDX_SC4: cur_next.sc4 = wbyte;
        adc_seq_pkg::IDX_CVH: cur_next.cmp_val[15:8] = wbyte;
        adc_seq_pkg::IDX_CVL: cur_next.cmp_val[7:0] = wbyte;
        adc_seq_pkg::IDX_PC1: cur_next.pc1 = wbyte;
        adc_seq_pkg::IDX_PC2: cur_next.pc2 = wbyte;
        adc_seq_pkg::IDX_IRQ_MASK: cur_next.irq_mask = wbyte[1:0];
        default: ;
      endcase
    end
    if (rd_en && idx == adc_seq_pkg::IDX_RL) begin
      cur_next.sc1[adc_seq_pkg::SC1_COMPLETE_BIT] = 1'b0;
    end

    if (sc1_wr) begin
      if (wbyte[4:0] == adc_seq_pkg::CH_DISABLED) begin
        halt = 1'b1;
        cur_next.fill_cnt = '0;
      end else if (fifo_mode) begin
        // Queue the channel in write order
        if (cur_reg.fill_cnt < depth) begin
          cur_next.queue[cur_reg.fill_cnt[PTR_W-1:0]] = wbyte[4:0];
          cur_next.fill_cnt = cur_reg.fill_cnt + CNT_ONE;
        end
        halt = (cur_reg.state == adc_seq_pkg::ST_CONVERT);
        // Without the hardware trigger, start when the queue reaches depth on this write
        if (!hw_mode && cur_reg.fill_cnt + CNT_ONE >= depth) begin
          start_req = 1'b1;
        end
      end else begin
        halt = (cur_reg.state == adc_seq_pkg::ST_CONVERT);
        start_req = !hw_mode;
      end
    end

    if (hw_mode && trig_edge && cur_reg.sc1[4:0] != adc_seq_pkg::CH_DISABLED &&
        (!fifo_mode || cur_reg.fill_cnt >= depth)) begin
      start_req = 1'b1;
    end

    if (halt && cur_reg.state == adc_seq_pkg::ST_CONVERT) begin
      cur_next.abort = 1'b1;
      abort_evt = 1'b1;
    end

    case (cur_reg.state)
      adc_seq_pkg::ST_IDLE, adc_seq_pkg::ST_FILL: begin
        cur_next.state = (fifo_mode && cur_next.fill_cnt != '0) ?
                         adc_seq_pkg::ST_FILL : adc_seq_pkg::ST_IDLE;
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (halt) begin
          cur_next.state = adc_seq_pkg::ST_IDLE;
        end else if (conv_done_i) begin
          cur_next.result = res_ext;
          if (cmp_true || !cur_reg.sc2[adc_seq_pkg::SC2_CMP_EN_BIT]) begin
            cur_next.set_hit = 1'b1;
          end
          if (!last_in_set) begin
            cur_next.rd_idx = cur_reg.rd_idx + CNT_ONE;
            cur_next.chan = cur_reg.queue[cur_next.rd_idx[PTR_W-1:0]];
            cur_next.start = 1'b1;
          end else begin
            complete_evt = cur_next.set_hit || cmp_true ||
                           !cur_reg.sc2[adc_seq_pkg::SC2_CMP_EN_BIT];
            if (cont) begin
              start_req = 1'b1;
            end else begin
              cur_next.state = adc_seq_pkg::ST_IDLE;
            end
          end
        end
      end
      default: cur_next.state = adc_seq_pkg::ST_IDLE;
    endcase

    if (start_req) begin
      cur_next.state = adc_seq_pkg::ST_CONVERT;
      cur_next.rd_idx = '0;
      cur_next.set_hit = 1'b0;
      cur_next.start = 1'b1;
      cur_next.chan = fifo_mode ? ((sc1_wr && cur_reg.fill_cnt == '0) ? wbyte[4:0] :
                      cur_next.queue[0]) : cur_next.sc1[4:0];
    end

    if (complete_evt) begin
      cur_next.sc1[adc_seq_pkg::SC1_COMPLETE_BIT] = 1'b1;
    end

    // Active follows the conversion state
    cur_next.sc2[adc_seq_pkg::SC2_ACTIVE_BIT] =
      (cur_next.state == adc_seq_pkg::ST_CONVERT);
    cur_next.sc2[adc_seq_pkg::SC2_FEMPTY_BIT] = (cur_next.fill_cnt == '0);

    // Sticky events: set wins over write-one-to-clear
    if (wr_en && idx == adc_seq_pkg::IDX_IRQ_STAT) begin
      cur_next.irq_stat = cur_reg.irq_stat & ~wbyte[1:0];
    end
    if (complete_evt) begin
      cur_next.irq_stat[adc_seq_pkg::IRQ_COMPLETE_BIT] = 1'b1;
    end
    if (abort_evt) begin
      cur_next.irq_stat[adc_seq_pkg::IRQ_ABORT_BIT] = 1'b1;
    end

    cur_next.rdata = '0;
    if (rd_en) begin
      case (idx)
        adc_seq_pkg::IDX_SC1: cur_next.rdata[7:0] = cur_reg.sc1;
        adc_seq_pkg::IDX_SC2: cur_next.rdata[7:0] = cur_reg.sc2;
        adc_seq_pkg::IDX_SC3: cur_next.rdata[7:0] = cur_reg.sc3;
        adc_seq_pkg::IDX_SC4: cur_next.rdata[7:0] = cur_reg.sc4;
        adc_seq_pkg::IDX_RH: cur_next.rdata[7:0] = cur_reg.result[15:8];
        adc_seq_pkg::IDX_RL: cur_next.rdata[7:0] = cur_reg.result[7:0];
        adc_seq_pkg::IDX_CVH: cur_next.rdata[7:0] = cur_reg.cmp_val[15:8];
        adc_seq_pkg::IDX_CVL: cur_next.rdata[7:0] = cur_reg.cmp_val[7:0];
        adc_seq_pkg::IDX_PC1: cur_next.rdata[7:0] = cur_reg.pc1;
        adc_seq_pkg::IDX_PC2: cur_next.rdata[7:0] = cur_reg.pc2;
        adc_seq_pkg::IDX_IRQ_STAT: cur_next.rdata[1:0] = cur_reg.irq_stat;
        adc_seq_pkg::IDX_IRQ_MASK: cur_next.rdata[1:0] = cur_reg.irq_mask;
        default: cur_next.rdata = '0;
      endcase
    end else begin
      cur_next.rdata = cur_reg.rdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cur_reg <= '0;
      cur_reg.state <= adc_seq_pkg::ST_IDLE;
      cur_reg.sc1 <= adc_seq_pkg::SC1_RST;
      cur_reg.sc2 <= adc_seq_pkg::SC2_RST;
      cur_reg.sc3 <= adc_seq_pkg::ZERO8;
      cur_reg.sc4 <= adc_seq_pkg::ZERO8;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Zero-wait slave: read data is decoded from registered state in the access phase
  always_comb begin
    prdata_o = '0;
    if (rd_en) begin
      prdata_o = cur_next.rdata;
    end
  end
  assign pready_o = 1'b1;
  assign pslverr_o = apb_access && !mapped;
  assign conv_start_o = cur_reg.start;
  assign conv_abort_o = cur_reg.abort;
  assign conv_channel_o = cur_reg.chan;
  assign conv_source_o = decode_src(cur_reg.chan);
  assign pin_control_one_o = cur_reg.pc1;
  assign pin_control_two_o = cur_reg.pc2;
  // Level output from the hardware flag gated by its enable, plus the status bits gated by the mask register
  assign irq_o = (cur_reg.sc1[adc_seq_pkg::SC1_COMPLETE_BIT] &&
                  cur_reg.sc1[adc_seq_pkg::SC1_IEN_BIT]) ||
                 (|(cur_reg.irq_stat & cur_reg.irq_mask));

endmodule

/* File: tb/conv_core_model.sv */
module conv_core_model (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic slow_i,
  input wire logic [4:0] channel_i,
  output logic done_o,
  output logic [11:0] result_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_reg;
  logic [11:0] val_reg;
  always_ff @(posedge clk_sys_i) begin
    done_o <= 1'h0;
    // Result lines toggle outside the done cycle so stale data never looks valid
    result_o <= ~result_o;
    if (srst_i) begin
      result_o <= 12'h000;
    end
    // A restart beside an abort wins: the new conversion replaces the old one
    if (srst_i) begin
      cnt_reg <= 5'h00;
    end else if (start_i) begin
      cnt_reg <= slow_i ? 5'h0c : 5'h02;
      val_reg <= {channel_i, 7'h15};
    end else if (abort_i) begin
      cnt_reg <= 5'h00;
    end else if (cnt_reg == 5'h01) begin
      cnt_reg <= 5'h00;
      done_o <= 1'h1;
      result_o <= val_reg;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
endmodule

/* File: tb/seq_checker.sv */
module seq_checker (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [adc_seq_pkg::ADDR_W+1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic conv_start_o,
  input wire logic conv_abort_o,
  input wire logic [4:0] conv_channel_o,
  input wire logic [2:0] conv_source_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic trig_reg;
  logic fifo_reg;
  wire acc = psel_i && penable_i;
  wire wr_sc1 = acc && pwrite_i && pstrb_i[0] && paddr_i[17:2] == 16'h0010;
  // Mode tracked from bus writes, since the checker cannot see registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      trig_reg <= 1'h0;
      fifo_reg <= 1'h0;
    end else if (acc && pwrite_i && pstrb_i[0]) begin
      if (paddr_i[17:2] == 16'h0011) trig_reg <= pwdata_i[6];
      if (paddr_i[17:2] == 16'h0013) fifo_reg <= pwdata_i[2:0] != 3'h0;
    end
  end
  function automatic logic mapped(input logic [15:0] i);
    return (i >= 16'h0010 && i <= 16'h0019) || i == 16'h30ac || i == 16'h30ad;
  endfunction
  function automatic logic [2:0] kind(input logic [4:0] c);
    if (c <= 5'h0f) return 3'h0;
    if (c <= 5'h13) return 3'h1;
    if (c == 5'h16) return 3'h2;
    if (c == 5'h17) return 3'h3;
    if (c == 5'h1d) return 3'h4;
    if (c == 5'h1e) return 3'h5;
    if (c == 5'h1f) return 3'h7;
    return 3'h6;
  endfunction
  bus_ready_a: assert property (acc |-> pready_o)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (acc |-> pslverr_o == !mapped(paddr_i[17:2]))
    else $error("pslverr does not match address map");
  idle_rdata_a: assert property (!(acc && !pwrite_i) |-> prdata_o == 32'h0)
    else $error("read data not zero outside read access");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  abort_pulse_a: assert property (conv_abort_o |=> !conv_abort_o)
    else $error("abort longer than one cycle");
  sw_start_a: assert property (wr_sc1 && pwdata_i[4:0] != 5'h1f && !trig_reg && !fifo_reg
    |=> conv_start_o && conv_channel_o == $past(pwdata_i[4:0]))
    else $error("write did not start conversion on channel");
  off_no_start_a: assert property (wr_sc1 && pwdata_i[4:0] == 5'h1f |=> !conv_start_o)
    else $error("start after disable code");
  src_decode_a: assert property ($stable(conv_channel_o) |-> conv_source_o == kind(conv_channel_o))
    else $error("source kind wrong for channel");
endmodule

/* File: tb/adc_conversion_sequencer_tb.sv */
module adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'h0, srst_i = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic trig = 1'h0, slow = 1'h1, prdy, perr, err, cst, cab, cdone, irq;
  logic [17:0] pa = 18'h0;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [4:0] cch, ch;
  logic [2:0] csrc;
  logic [11:0] cres;
  logic [7:0] pc1, pc2, v;
  logic [3:0] pst = 4'hf;
  logic [4:0] chans[$];
  int fails = 0, compares = 0, starts = 0, cyc = 0, seed = 32'hb424;
  always #25 clk_sys_i = ~clk_sys_i;
  adc_conversion_sequencer dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .hardware_trigger_input_i(trig),
    .conv_start_o(cst), .conv_abort_o(cab), .conv_channel_o(cch), .conv_source_o(csrc),
    .conv_done_i(cdone), .conv_result_i(cres), .pin_control_one_o(pc1),
    .pin_control_two_o(pc2), .irq_o(irq));
  conv_core_model core_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .start_i(cst),
    .abort_i(cab), .slow_i(slow), .channel_i(cch), .done_o(cdone), .result_o(cres));
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (psel && pen && prdy) begin
      rd <= prd;
      err <= perr;
    end
    if (cst === 1'h1) begin
      starts++;
      chans.push_back(cch);
    end
    if (cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
    @(posedge clk_sys_i);
    psel <= 1'h1;
    pwr <= w;
    pa <= {i, 2'h0};
    pwd <= {24'h0, d};
    @(posedge clk_sys_i);
    pen <= 1'h1;
    do @(posedge clk_sys_i); while (prdy !== 1'h1);
    psel <= 1'h0;
    pen <= 1'h0;
    #1;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    apb(1'h1, i, d);
  endtask
  task automatic rdr(input logic [15:0] i);
    apb(1'h0, i, 8'h00);
  endtask
  task automatic wdone();
    // No local limit: a lost done runs into the bench timeout and fails
    while (cdone !== 1'h1) begin
      @(posedge clk_sys_i);
    end
    repeat (2) @(posedge clk_sys_i);
  endtask
  function automatic logic [11:0] res(input logic [4:0] c);
    return {c, 7'h15};
  endfunction
  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      rdr(i < 8 ? 16'(16'h0010 + i) : 16'(16'h30a4 + i));
      chk(rd, i == 0 ? 32'h1f : i == 1 ? 32'h08 : 32'h0);
    end
    rdr(16'h001a);
    chk(err, 1);
    chk(rd, 0);
    v = 8'($random(seed));
    wr(16'h30ac, v);
    chk(pc1, v);
    @(posedge clk_sys_i);
    pst <= 4'he;
    wr(16'h30ac, ~v);
    chk(pc1, v);
    @(posedge clk_sys_i);
    pst <= 4'hf;
    wr(16'h30ad, v);
    chk(pc2, v);
    for (int i = 0; i < 4; i++) begin
      ch = 5'($random(seed)) & 5'h0f;
      wr(16'h0010, {3'h2, ch});
      rdr(16'h0011);
      chk(rd[7], 1);
      wdone();
      rdr(16'h0011);
      chk(rd[7], 0);
      rdr(16'h0010);
      chk(rd, {24'h0, 3'h6, ch});
      chk(irq, 1);
      rdr(16'h0014);
      chk(rd, res(ch) >> 8);
      rdr(16'h0015);
      chk(rd, res(ch) & 12'h0ff);
      rdr(16'h0010);
      chk({irq, rd[7]}, 0);
    end
    wr(16'h0010, 8'h02);
    wr(16'h0010, 8'h05);
    wdone();
    rdr(16'h0014);
    chk(rd, 32'h2);
    wr(16'h0010, 8'h03);
    wr(16'h0010, 8'h1f);
    repeat (15) @(posedge clk_sys_i);
    rdr(16'h0010);
    chk(rd, 32'h1f);
    rdr(16'h0011);
    chk(rd[7], 0);
    wr(16'h0018, 8'h03);
    wr(16'h0010, 8'h07);
    wdone();
    chk(irq, 0);
    rdr(16'h0018);
    chk(rd[0], 1);
    wr(16'h0019, 8'h01);
    chk(irq, 1);
    wr(16'h0018, 8'h01);
    chk(irq, 0);
    slow <= 1'h0;
    wr(16'h0016, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(16'h0011, i[1] ? 8'h30 : 8'h20);
      wr(16'h0010, i[0] ? 8'h05 : 8'h03);
      wdone();
      rdr(16'h0010);
      chk(rd[7], i[0] == i[1]);
    end
    wr(16'h0011, 8'h00);
    for (int k = 0; k < 6; k++) begin
      wr(16'h0010, {3'h0, k < 2 ? 5'(5'h10 + 3 * k) : k < 4 ? 5'(5'h14 + k) : 5'(5'h19 + k)});
      chk(csrc, k < 2 ? 1 : k);
      wdone();
    end
    wr(16'h0010, 8'h14);
    chk(csrc, 3'h6);
    wdone();
    slow <= 1'h1;
    wr(16'h0013, 8'h03);
    wr(16'h0010, 8'h1f);
    starts = 0;
    chans.delete();
    wr(16'h0010, 8'h09);
    wr(16'h0010, 8'h04);
    repeat (3) @(posedge clk_sys_i);
    chk(starts, 0);
    wr(16'h0010, 8'h0c);
    wdone();
    rdr(16'h0010);
    chk(rd[7], 0);
    wdone();
    wdone();
    rdr(16'h0010);
    chk(rd[7], 1);
    chk(starts, 3);
    chk({chans[0], chans[1], chans[2]}, {5'h09, 5'h04, 5'h0c});
    slow <= 1'h0;
    wr(16'h0010, 8'h1f);
    starts = 0;
    chans.delete();
    wr(16'h0010, 8'h29);
    wr(16'h0010, 8'h24);
    wr(16'h0010, 8'h2c);
    repeat (6) wdone();
    chk(starts >= 6, 1);
    chk({chans[3], chans[4], chans[5]}, {5'h09, 5'h04, 5'h0c});
    wr(16'h0010, 8'h1f);
    wr(16'h0013, 8'h00);
    wr(16'h0011, 8'h40);
    starts = 0;
    wr(16'h0010, 8'h0a);
    repeat (4) @(posedge clk_sys_i);
    chk(starts, 0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      trig <= 1'h1;
      @(posedge clk_sys_i);
      trig <= 1'h0;
      wdone();
    end
    chk(starts, 2);
    // Reset in the middle of a triggered conversion
    @(posedge clk_sys_i);
    trig <= 1'h1;
    @(posedge clk_sys_i);
    trig <= 1'h0;
    srst_i <= 1'h1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    rdr(16'h0011);
    chk(rd, 32'h08);
    rdr(16'h0010);
    chk(rd, 32'h1f);
    end_of_test();
  end
endmodule
bind adc_conversion_sequencer seq_checker chk_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
  .conv_channel_o(conv_channel_o), .conv_source_o(conv_source_o));
